// file: bp_delay_timer.sv
`include "bp_map.svh"

module bp_delay_timer #(
  parameter int unsigned CNT_W = 32
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // qualifying condition and length
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] limit,
  // condition held for limit cycles
  output logic                  done
);

  logic [CNT_W-1:0] countQ;
  logic [CNT_W-1:0] countD;
  logic             doneQ;
  logic             doneD;
  logic             atEnd;

  assign atEnd  = (countQ >= limit - CNT_W'(1));
  // a dropped condition clears the count so only an unbroken run fires
  assign countD = (!run || doneQ) ? '0 : countQ + CNT_W'(1);
  assign doneD  = run && (doneQ || atEnd);
  assign done   = doneQ;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      countQ <= '0;
      doneQ  <= 1'b0;
    end else begin
      countQ <= countD;
      doneQ  <= doneD;
    end
  end

endmodule : bp_delay_timer

// file: bp_map.svh
`ifndef BP_MAP_SVH
`define BP_MAP_SVH

// clock rate in kHz, so a time in ms times this gives cycles
`define BP_CLK_KHZ        200000.0

// delay times in ms (over-charge pair has no printed figure)
`define BP_TD1_MS         1000.0
`define BP_TR1_MS         1.0
`define BP_TD2_MS         100.0
`define BP_TR2_MS         1.0
`define BP_TD3_MS         20.0
`define BP_TR3_MS         1.0
`define BP_TD4_MS         0.250
`define BP_TD5_MS         1.5
`define BP_TR5_MS         1.5

// counter-derived delays other than the short-circuit one are divided by this in shortened mode
`define BP_SHORTEN_DIV    64

// delay counter slots
`define BP_T_OCHG_DET     0
`define BP_T_OCHG_REL     1
`define BP_T_ODIS_DET     2
`define BP_T_ODIS_REL     3
`define BP_T_OCUR_DET     4
`define BP_T_OCUR_REL     5
`define BP_T_SHORT_DET    6
`define BP_T_XCHG_DET     7
`define BP_T_XCHG_REL     8
`define BP_T_COUNT        9

// output levels
`define BP_GATE_ON        1'b1
`define BP_GATE_OFF       1'b0

`endif

// file: bp_pack_model.sv
module bp_pack_model #(
  parameter int OCHG_MV = 4300, parameter int REL_MV = 4100, parameter int RELS_MV = 4250,
  parameter int ODIS_MV = 2200, parameter int OCUR_MV = 200, parameter int SHORT_MV = 1300,
  parameter int XCHG_MV = -450, parameter int STB_MV = 3500, parameter int PULL_MV = 8000
) (
  // pack state
  input  wire logic signed [15:0] cellA,
  input  wire logic signed [15:0] cellB,
  input  wire logic signed [15:0] senseMv,
  input  wire logic               loadConnected,
  input  wire logic               charger,
  // controls from the block
  input  wire logic               pullUpEn,
  input  wire logic               pullDownEn,
  input  wire logic               hysSmall,
  // comparator results
  output logic                    cellOverCharge,
  output logic                    cellChargeReleased,
  output logic                    cellOverDischarge,
  output logic                    cellDischargeOk,
  output logic                    senseOverCurrent,
  output logic                    senseShort,
  output logic                    senseExcessCharger,
  output logic                    standbyRelease,
  output logic                    zeroVoltCharge
);
  // pull-down empties the node once the load is gone; pull-up lifts it with no charger
  wire signed [15:0] node = (pullDownEn && !loadConnected) ? 16'sh0000 :
                            (pullUpEn && !charger) ? 16'(PULL_MV) : senseMv;
  wire signed [15:0] rel  = hysSmall ? 16'(RELS_MV) : 16'(REL_MV);
  assign cellOverCharge     = cellA >= OCHG_MV || cellB >= OCHG_MV;
  assign cellChargeReleased = cellA <= rel && cellB <= rel;
  assign cellOverDischarge  = cellA <= ODIS_MV || cellB <= ODIS_MV;
  assign cellDischargeOk    = cellA >= ODIS_MV && cellB >= ODIS_MV;
  assign senseOverCurrent   = node >= OCUR_MV;
  assign senseShort         = node >= SHORT_MV;
  assign senseExcessCharger = node <= XCHG_MV;
  assign standbyRelease     = node <= STB_MV;
  assign zeroVoltCharge     = cellA == 0 && cellB == 0 && charger;
endmodule : bp_pack_model

// file: bp_pkg.sv
package bp_pkg;

  typedef enum logic [1:0] {
    BP_CHG_NORMAL,
    BP_CHG_OVERCHARGE,
    BP_CHG_EXCESS
  } bp_chg_state_e;

  typedef enum logic [2:0] {
    BP_DIS_NORMAL,
    BP_DIS_OVERDISCH,
    BP_DIS_RECOVER,
    BP_DIS_OVERCURR
  } bp_dis_state_e;

endpackage : bp_pkg

// file: bp_protect_fsm.sv
// Behaviour
// [R1] either cell over-charged for the detection delay drops the charge gate
// [R2] load connected during over-charge selects the small comparator hysteresis
// [R3] over-charge state blocks over-current detection, short detection stays live
// [R4] both cells released, and sense low or load present, raises charge gate after delay
// [R5] load present but a cell still above release keeps charge gate low
// [R6] excessive-charger detection starts after over-charge release
// [R7] either cell over-discharged for the qualifying delay drops the discharge gate
// [R8] over-discharge enters stand-by and enables the pull-up on the sense node
// [R9] stand-by ends only when the charger pulls the sense node below release
// [R10] both cells above over-discharge level raise discharge gate after release delay
// [R11] over-current for its delay drops discharge gate and enables the pull-down
// [R12] short circuit acts like over-current with a shorter delay
// [R13] over-current or short never enters stand-by
// [R14] sense back below over-current threshold raises discharge gate after release delay
// [R15] excessive charger for its delay drops the charge gate
// [R16] excessive charger clearing before the delay abandons the detection
// [R17] excessive charger clearing after detection raises charge gate after release delay
// [R18] no excessive-charger detection while the discharge gate is low
// [R19] a persisting excessive charger starts its delay when discharge gate rises
// [R20] zero-volt cells with enough charger voltage get the charge gate high
// [R21] shorten select divides all counter delays, short-circuit delay excepted
// [R22] over-discharge detection delay is 100 ms
// [R23] over-current detection delay is 20.0 ms
// [R24] short-circuit detection delay is 0.250 ms
// [R25] a delay count restarts whenever its condition drops before completion
`include "bp_map.svh"

module bp_protect_fsm #(
  parameter int unsigned CNT_W          = 32,
  parameter int unsigned SHORTEN_DIV    = `BP_SHORTEN_DIV,
  parameter int unsigned OCHG_DET_CYC   = int'($ceil(`BP_TD1_MS * `BP_CLK_KHZ)),
  parameter int unsigned OCHG_REL_CYC   = int'($ceil(`BP_TR1_MS * `BP_CLK_KHZ)),
  parameter int unsigned ODIS_DET_CYC   = int'($ceil(`BP_TD2_MS * `BP_CLK_KHZ)),
  parameter int unsigned ODIS_REL_CYC   = int'($ceil(`BP_TR2_MS * `BP_CLK_KHZ)),
  parameter int unsigned OCUR_DET_CYC   = int'($ceil(`BP_TD3_MS * `BP_CLK_KHZ)),
  parameter int unsigned OCUR_REL_CYC   = int'($ceil(`BP_TR3_MS * `BP_CLK_KHZ)),
  parameter int unsigned SHORT_DET_CYC  = int'($ceil(`BP_TD4_MS * `BP_CLK_KHZ)),
  parameter int unsigned XCHG_DET_CYC   = int'($ceil(`BP_TD5_MS * `BP_CLK_KHZ)),
  parameter int unsigned XCHG_REL_CYC   = int'($ceil(`BP_TR5_MS * `BP_CLK_KHZ))
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // cell comparators
  input  wire logic cellOverCharge,
  input  wire logic cellChargeReleased,
  input  wire logic cellOverDischarge,
  input  wire logic cellDischargeOk,
  // charger_minus_level comparators
  input  wire logic senseOverCurrent,
  input  wire logic senseShort,
  input  wire logic senseExcessCharger,
  input  wire logic standbyRelease,
  // load, zero-volt charging and delay shortening
  input  wire logic loadConnected,
  input  wire logic zeroVoltCharge,
  input  wire logic delayShorten,
  // gate drives
  output logic      chargeGate,
  output logic      dischargeGate,
  // sense node resistors and comparator control
  output logic      pullUpEn,
  output logic      pullDownEn,
  output logic      hysSmall,
  output logic      standby
);

  // elaboration checks
  // the counter must hold the longest delay,
  // which is the over-charge or over-discharge one

  localparam int unsigned MAX_CYC = (ODIS_DET_CYC > OCHG_DET_CYC) ? ODIS_DET_CYC : OCHG_DET_CYC;

  if (CNT_W < 2 || CNT_W > 32 || CNT_W < $clog2(MAX_CYC + 1)) begin : gCntCheck
    $error("counter width cannot hold the longest delay");
  end
  if (SHORTEN_DIV < 1) begin : gDivCheck
    $error("shorten divisor must be at least one");
  end
  if (OCHG_DET_CYC < 1 || OCHG_REL_CYC < 1 || ODIS_DET_CYC < 1 || ODIS_REL_CYC < 1 ||
      OCUR_DET_CYC < 1 || OCUR_REL_CYC < 1 || SHORT_DET_CYC < 1 ||
      XCHG_DET_CYC < 1 || XCHG_REL_CYC < 1) begin : gCycCheck
    $error("every delay needs at least one cycle");
  end


  // shortened length of a counter delay, never below one cycle
  // a zero limit would wrap limit - 1 and keep a timer from firing for 2^CNT_W cycles
  function automatic logic [CNT_W-1:0] delayLimit(
    input logic [CNT_W-1:0] cycles,
    input logic             shortOn,
    input logic             exempt
  );
    logic [CNT_W-1:0] cut;
    cut = cycles / CNT_W'(SHORTEN_DIV);
    if (cut == '0) begin
      cut = CNT_W'(1);
    end
    delayLimit = (shortOn && !exempt) ? cut : cycles; // R21
  endfunction : delayLimit

  // state
  // charge and discharge sides run side by side
  bp_pkg::bp_chg_state_e chgStateQ;
  bp_pkg::bp_chg_state_e chgStateD;
  bp_pkg::bp_dis_state_e disStateQ;
  bp_pkg::bp_dis_state_e disStateD;


  // output flops, one per port
  logic chargeGateQ;
  logic chargeGateD;

  logic dischargeGateQ;
  logic dischargeGateD;

  logic pullUpQ;
  logic pullUpD;

  logic pullDownQ;
  logic pullDownD;

  logic hysSmallQ;
  logic hysSmallD;

  logic standbyQ;
  logic standbyD;


  // delay counters
  // one timer per delay, so no two delays
  // ever share or corrupt a count
  logic [`BP_T_COUNT-1:0] timerRun;
  logic [`BP_T_COUNT-1:0] timerDone;
  logic [CNT_W-1:0]       timerCyc   [`BP_T_COUNT];
  logic [CNT_W-1:0]       timerLimit [`BP_T_COUNT];
  logic [`BP_T_COUNT-1:0] timerExempt;

  assign timerCyc[`BP_T_OCHG_DET]  = CNT_W'(OCHG_DET_CYC);
  assign timerCyc[`BP_T_OCHG_REL]  = CNT_W'(OCHG_REL_CYC);
  assign timerCyc[`BP_T_ODIS_DET]  = CNT_W'(ODIS_DET_CYC); // R22
  assign timerCyc[`BP_T_ODIS_REL]  = CNT_W'(ODIS_REL_CYC);
  assign timerCyc[`BP_T_OCUR_DET]  = CNT_W'(OCUR_DET_CYC); // R23
  assign timerCyc[`BP_T_OCUR_REL]  = CNT_W'(OCUR_REL_CYC);
  assign timerCyc[`BP_T_SHORT_DET] = CNT_W'(SHORT_DET_CYC); // R24
  assign timerCyc[`BP_T_XCHG_DET]  = CNT_W'(XCHG_DET_CYC);
  assign timerCyc[`BP_T_XCHG_REL]  = CNT_W'(XCHG_REL_CYC);

  // the short-circuit delay is not counter-shortened
  always_comb begin
    timerExempt                  = '0;
    timerExempt[`BP_T_SHORT_DET] = 1'b1; // R21
  end

  // state decodes
  wire logic inOverCharge = (chgStateQ == bp_pkg::BP_CHG_OVERCHARGE);
  wire logic inChgNormal  = (chgStateQ == bp_pkg::BP_CHG_NORMAL);
  wire logic inExcess     = (chgStateQ == bp_pkg::BP_CHG_EXCESS);
  wire logic inDisNormal  = (disStateQ == bp_pkg::BP_DIS_NORMAL);
  wire logic inOverDisch  = (disStateQ == bp_pkg::BP_DIS_OVERDISCH);
  wire logic inRecover    = (disStateQ == bp_pkg::BP_DIS_RECOVER);
  wire logic inOverCurr   = (disStateQ == bp_pkg::BP_DIS_OVERCURR);


  // qualifying conditions
  // each run term is the whole condition for its delay;
  // a timer only restarts, never pauses
  wire logic ochgRelOk   = cellChargeReleased && (!senseOverCurrent || loadConnected); // R4 R5
  wire logic xchgAllowed = dischargeGateQ && inChgNormal; // R18 R19 R6

  assign timerRun[`BP_T_OCHG_DET]  = cellOverCharge && !inOverCharge; // R1
  assign timerRun[`BP_T_OCHG_REL]  = inOverCharge && ochgRelOk; // R4 R5
  assign timerRun[`BP_T_ODIS_DET]  = cellOverDischarge && (inDisNormal || inOverCurr); // R7
  assign timerRun[`BP_T_ODIS_REL]  = inRecover && cellDischargeOk; // R10
  assign timerRun[`BP_T_OCUR_DET]  = senseOverCurrent && inDisNormal && !inOverCharge; // R3 R11
  assign timerRun[`BP_T_OCUR_REL]  = inOverCurr && !senseOverCurrent; // R14
  assign timerRun[`BP_T_SHORT_DET] = senseShort && inDisNormal; // R3 R12
  assign timerRun[`BP_T_XCHG_DET]  = senseExcessCharger && xchgAllowed; // R15 R16
  assign timerRun[`BP_T_XCHG_REL]  = inExcess && !senseExcessCharger; // R17


  // shortening is applied to the limit, not the count,
  // so a change of the select takes effect at once
  for (genvar t = 0; t < `BP_T_COUNT; t++) begin : gTimer
    assign timerLimit[t] = delayLimit(timerCyc[t], delayShorten, timerExempt[t]);

    bp_delay_timer #(
      .CNT_W (CNT_W)
    ) uTimer (
      .core_clk (core_clk),
      .reset    (reset),
      .run      (timerRun[t]), // R25
      .limit    (timerLimit[t]),
      .done     (timerDone[t])
    );
  end


  // charge side
  //   normal -> over-charge after detection delay
  //   over-charge -> normal after release delay
  //   normal -> excess after excess delay
  //   excess -> normal after its release delay
  // over-charge wins when both complete together,
  // so a high charger never masks a full cell
  always_comb begin
    chgStateD = chgStateQ;
    case (chgStateQ)
      bp_pkg::BP_CHG_NORMAL: begin
        if (timerDone[`BP_T_OCHG_DET]) begin
          chgStateD = bp_pkg::BP_CHG_OVERCHARGE; // R1
        end else if (timerDone[`BP_T_XCHG_DET]) begin
          chgStateD = bp_pkg::BP_CHG_EXCESS; // R15
        end
      end
      bp_pkg::BP_CHG_OVERCHARGE: begin
        // excessive-charger watch resumes from normal after release
        if (timerDone[`BP_T_OCHG_REL]) begin
          chgStateD = bp_pkg::BP_CHG_NORMAL; // R4 R6
        end
      end
      bp_pkg::BP_CHG_EXCESS: begin
        if (timerDone[`BP_T_OCHG_DET]) begin
          chgStateD = bp_pkg::BP_CHG_OVERCHARGE;
        end else if (timerDone[`BP_T_XCHG_REL]) begin
          chgStateD = bp_pkg::BP_CHG_NORMAL; // R17
        end
      end
      default: begin
        chgStateD = bp_pkg::BP_CHG_NORMAL;
      end
    endcase
  end


  // discharge side
  //   normal -> over-discharge after detection delay
  //   normal -> over-current on either current delay
  //   over-current -> normal after release delay
  //   over-discharge -> recover on stand-by release
  //   recover -> normal after release delay
  // over-discharge wins: a drained pack must sleep
  // even while a current fault is still pending
  always_comb begin
    disStateD = disStateQ;
    case (disStateQ)
      bp_pkg::BP_DIS_NORMAL: begin
        if (timerDone[`BP_T_ODIS_DET]) begin
          disStateD = bp_pkg::BP_DIS_OVERDISCH; // R7
        end else if (timerDone[`BP_T_SHORT_DET] || timerDone[`BP_T_OCUR_DET]) begin
          disStateD = bp_pkg::BP_DIS_OVERCURR; // R11 R12
        end
      end
      bp_pkg::BP_DIS_OVERDISCH: begin
        // cell monitoring is frozen until the charger appears
        if (standbyRelease) begin
          disStateD = bp_pkg::BP_DIS_RECOVER; // R9
        end
      end
      bp_pkg::BP_DIS_RECOVER: begin
        if (timerDone[`BP_T_ODIS_REL]) begin
          disStateD = bp_pkg::BP_DIS_NORMAL; // R10
        end
      end
      bp_pkg::BP_DIS_OVERCURR: begin
        if (timerDone[`BP_T_ODIS_DET]) begin
          disStateD = bp_pkg::BP_DIS_OVERDISCH;
        end else if (timerDone[`BP_T_OCUR_REL]) begin
          disStateD = bp_pkg::BP_DIS_NORMAL; // R14
        end
      end
      default: begin
        disStateD = bp_pkg::BP_DIS_NORMAL;
      end
    endcase
  end


  // output decode from the next state so each output is one flop
  // gates therefore turn on the same edge as the state
  wire logic chgNextNormal = (chgStateD == bp_pkg::BP_CHG_NORMAL);
  wire logic chgNextOver   = (chgStateD == bp_pkg::BP_CHG_OVERCHARGE);
  wire logic disNextNormal = (disStateD == bp_pkg::BP_DIS_NORMAL);
  wire logic disNextOd     = (disStateD == bp_pkg::BP_DIS_OVERDISCH);
  wire logic disNextOc     = (disStateD == bp_pkg::BP_DIS_OVERCURR);

  assign chargeGateD    = chgNextNormal || zeroVoltCharge; // R1 R5 R15 R20
  assign dischargeGateD = disNextNormal; // R7 R11 R12
  assign pullUpD        = disNextOd; // R8
  assign pullDownD      = disNextOc; // R11 R12
  assign standbyD       = disNextOd; // R8 R13
  assign hysSmallD      = chgNextOver && (hysSmallQ || loadConnected); // R2

  // state flops
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      chgStateQ <= bp_pkg::BP_CHG_NORMAL;
      disStateQ <= bp_pkg::BP_DIS_NORMAL;
    end else begin
      chgStateQ <= chgStateD;
      disStateQ <= disStateD;
    end
  end


  // output flops; both gates on out of reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      chargeGateQ    <= `BP_GATE_ON;
      dischargeGateQ <= `BP_GATE_ON;
      pullUpQ        <= 1'b0;
      pullDownQ      <= 1'b0;
      hysSmallQ      <= 1'b0;
      standbyQ       <= 1'b0;
    end else begin
      chargeGateQ    <= chargeGateD;
      dischargeGateQ <= dischargeGateD;
      pullUpQ        <= pullUpD;
      pullDownQ      <= pullDownD;
      hysSmallQ      <= hysSmallD;
      standbyQ       <= standbyD;
    end
  end


  // ports come straight from the flops
  assign chargeGate    = chargeGateQ;
  assign dischargeGate = dischargeGateQ;
  assign pullUpEn      = pullUpQ;
  assign pullDownEn    = pullDownQ;
  assign hysSmall      = hysSmallQ;
  assign standby       = standbyQ;

endmodule : bp_protect_fsm

// file: bp_protect_fsm_chk.sv
module bp_protect_fsm_chk #(
  parameter int unsigned OCUR_DET_CYC  = 8,
  parameter int unsigned OCUR_REL_CYC  = 6,
  parameter int unsigned SHORT_DET_CYC = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // comparators and controls
  input wire logic cellOverCharge,
  input wire logic cellOverDischarge,
  input wire logic senseOverCurrent,
  input wire logic senseShort,
  input wire logic standbyRelease,
  input wire logic zeroVoltCharge,
  input wire logic delayShorten,
  // block outputs
  input wire logic chargeGate,
  input wire logic dischargeGate,
  input wire logic pullUpEn,
  input wire logic pullDownEn,
  input wire logic hysSmall,
  input wire logic standby
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // unbroken run lengths of conditions that must end in a gate change
  wire       ocRun    = senseOverCurrent && chargeGate && dischargeGate && !zeroVoltCharge
                        && !delayShorten;
  wire       relRun   = pullDownEn && !senseOverCurrent && !cellOverDischarge && !delayShorten;
  wire       shRun    = senseShort && dischargeGate;
  logic [7:0] ocCnt_q, relCnt_q, shCnt_q;
  wire [7:0] ocCnt_d  = ocRun ? ocCnt_q + 8'h01 : 8'h00;
  wire [7:0] relCnt_d = relRun ? relCnt_q + 8'h01 : 8'h00;
  wire [7:0] shCnt_d  = shRun ? shCnt_q + 8'h01 : 8'h00;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ocCnt_q  <= 8'h00;
      relCnt_q <= 8'h00;
      shCnt_q  <= 8'h00;
    end else begin
      ocCnt_q  <= ocCnt_d;
      relCnt_q <= relCnt_d;
      shCnt_q  <= shCnt_d;
    end
  end

  sequence s_wake;
    standby && standbyRelease;
  endsequence

  a_reset_values: assert property ($fell(reset) |-> chargeGate && dischargeGate && !standby
    && !pullUpEn && !pullDownEn && !hysSmall) else $error("bad state after reset");
  a_short_drop: assert property (shCnt_q == SHORT_DET_CYC |-> ##[1:3] !dischargeGate)
    else $error("short kept discharge on");
  a_ocur_drop: assert property (ocCnt_q == OCUR_DET_CYC |-> ##[1:3] !dischargeGate)
    else $error("over-current kept discharge on");
  a_ocur_release: assert property (relCnt_q == OCUR_REL_CYC |-> ##[1:3] dischargeGate)
    else $error("over-current release late");
  a_pulldown_gate: assert property (pullDownEn |-> !dischargeGate && !standby)
    else $error("pull-down in wrong state");
  a_pullup_standby: assert property (pullUpEn |-> standby && !dischargeGate)
    else $error("pull-up in wrong state");
  a_standby_hold: assert property (standby && !standbyRelease |=> standby)
    else $error("standby left early");
  a_standby_exit: assert property (s_wake |=> !standby && !pullUpEn)
    else $error("standby not left");
  a_hys_gate: assert property (hysSmall && !zeroVoltCharge |-> !chargeGate || $rose(chargeGate))
    else $error("small hysteresis outside over-charge");
  a_zero_volt: assert property (zeroVoltCharge |=> chargeGate)
    else $error("zero volt charge blocked");
  a_excess_wait: assert property ($rose(dischargeGate) && chargeGate && !cellOverCharge
    && !delayShorten |-> chargeGate [*6]) else $error("excess delay started early");
endmodule : bp_protect_fsm_chk

bind bp_protect_fsm bp_protect_fsm_chk #(
  .OCUR_DET_CYC(OCUR_DET_CYC), .OCUR_REL_CYC(OCUR_REL_CYC), .SHORT_DET_CYC(SHORT_DET_CYC)
) chk (
  .core_clk, .reset, .cellOverCharge, .cellOverDischarge, .senseOverCurrent, .senseShort,
  .standbyRelease, .zeroVoltCharge, .delayShorten, .chargeGate, .dischargeGate, .pullUpEn,
  .pullDownEn, .hysSmall, .standby
);

// file: bp_protect_fsm_tb.sv
`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      $display("wrong value %s expected %0d seen %0d", what, exp, got); \
      fail_count++; \
    end \
  end

module bp_protect_fsm_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DIV = 4, TD1 = 12, TR1 = 6, TD2 = 10, TR2 = 6, TD3 = 8, TR3 = 6, TD4 = 4;
  localparam int TD5 = 7, TR5 = 5;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic delayShorten = 1'b0;
  logic loadConnected = 1'b0;
  logic charger = 1'b0;
  logic signed [15:0] cellA = 16'sh0E10, cellB = 16'sh0E10, senseMv = 16'sh0000;
  logic cellOverCharge, cellChargeReleased, cellOverDischarge, cellDischargeOk, zeroVoltCharge;
  logic senseOverCurrent, senseShort, senseExcessCharger, standbyRelease;
  logic chargeGate, dischargeGate, pullUpEn, pullDownEn, hysSmall, standby;
  integer seed = 32'hF0173E80;
  int fail_count = 0;
  int n_checks = 0;
  int r;

  always #2.5 core_clk = ~core_clk;

  bp_protect_fsm #(.SHORTEN_DIV(DIV), .OCHG_DET_CYC(TD1), .OCHG_REL_CYC(TR1),
    .ODIS_DET_CYC(TD2), .ODIS_REL_CYC(TR2), .OCUR_DET_CYC(TD3), .OCUR_REL_CYC(TR3),
    .SHORT_DET_CYC(TD4), .XCHG_DET_CYC(TD5), .XCHG_REL_CYC(TR5)) DUT (.core_clk, .reset,
    .cellOverCharge, .cellChargeReleased, .cellOverDischarge, .cellDischargeOk,
    .senseOverCurrent, .senseShort, .senseExcessCharger, .standbyRelease, .loadConnected,
    .zeroVoltCharge, .delayShorten, .chargeGate, .dischargeGate, .pullUpEn, .pullDownEn,
    .hysSmall, .standby);

  bp_pack_model pack_i (.cellA, .cellB, .senseMv, .loadConnected, .charger, .pullUpEn,
    .pullDownEn, .hysSmall, .cellOverCharge, .cellChargeReleased, .cellOverDischarge,
    .cellDischargeOk, .senseOverCurrent, .senseShort, .senseExcessCharger, .standbyRelease,
    .zeroVoltCharge);

  function automatic int dly(input int n, input bit sh);
    return !sh ? n : (n / DIV < 1 ? 1 : n / DIV);
  endfunction : dly

  function automatic logic outSel(input int s);
    return s == 0 ? chargeGate : (s == 1 ? dischargeGate : standby);
  endfunction : outSel

  task automatic pack(input int a, input int b, input int s, input logic ld, input logic ch);
    @(posedge core_clk);
    #1;
    cellA = 16'(a);
    cellB = 16'(b);
    senseMv = 16'(s);
    loadConnected = ld;
    charger = ch;
  endtask : pack

  task automatic idle(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : idle

  // output turns one cycle after the delay; one cycle of slack either way
  task automatic waitFor(input int s, input logic lvl, input int n0, input string what);
    int n;
    n = 0;
    while (outSel(s) !== lvl && n < 60) begin
      idle(1);
      n++;
    end
    if (n >= n0 && n <= n0 + 2) n = n0 + 1;
    `CHK(what, n0 + 1, n)
  endtask : waitFor

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    idle(10);
    reset = 1'b0;
    pack(4350, 3800, 0, 1'b0, 1'b0);
    waitFor(0, 1'b0, TD1, "ochg");
    pack(4350, 3800, 300, 1'b0, 1'b0);
    idle(30);
    `CHK("oc in ochg", 1'b1, dischargeGate)
    pack(4350, 3800, 1500, 1'b0, 1'b0);
    waitFor(1, 1'b0, TD4, "short");
    `CHK("pull-down", 1'b1, pullDownEn)
    pack(4350, 3800, 0, 1'b0, 1'b0);
    waitFor(1, 1'b1, TR3, "short rel");
    pack(4280, 3800, 300, 1'b1, 1'b0);
    idle(30);
    `CHK("hys", 1'b1, hysSmall)
    `CHK("held ochg", 1'b0, chargeGate)
    pack(4200, 3800, 300, 1'b1, 1'b0);
    waitFor(0, 1'b1, TR1, "ochg rel");
    pack(3600, 3600, 0, 1'b0, 1'b1);
    idle(30);
    $display("test overcharge done");
    pack(3600, 3600, -600, 1'b0, 1'b1);
    idle(4);
    pack(3600, 3600, 0, 1'b0, 1'b1);
    idle(20);
    `CHK("xchg abort", 1'b1, chargeGate)
    pack(3600, 3600, -600, 1'b0, 1'b1);
    waitFor(0, 1'b0, TD5, "xchg");
    pack(3600, 3600, 0, 1'b0, 1'b1);
    waitFor(0, 1'b1, TR5, "xchg rel");
    $display("test excess done");
    pack(2000, 3600, 0, 1'b0, 1'b0);
    waitFor(1, 1'b0, TD2, "odis");
    idle(1);
    `CHK("standby", 1'b1, standby)
    `CHK("pull-up", 1'b1, pullUpEn)
    `CHK("no pull-down", 1'b0, pullDownEn)
    pack(3600, 3600, 0, 1'b0, 1'b0);
    idle(30);
    `CHK("standby held", 1'b1, standby)
    pack(3600, 3600, -600, 1'b0, 1'b1);
    waitFor(2, 1'b0, 0, "wake");
    waitFor(1, 1'b1, TR2, "odis rel");
    waitFor(0, 1'b0, TD5, "xchg late");
    pack(3600, 3600, 0, 1'b0, 1'b0);
    waitFor(0, 1'b1, TR5, "xchg rel2");
    $display("test discharge done");
    delayShorten = 1'b1;
    for (int i = 0; i < 4; i++) begin
      pack(3600, 3600, i[0] ? 1500 : 300, 1'b0, 1'b0);
      // a short level also trips over-current, so the shorter delay wins
      waitFor(1, 1'b0, (i[0] && TD4 < dly(TD3, 1'b1)) ? TD4 : dly(TD3, 1'b1), "fast det");
      pack(3600, 3600, 0, 1'b0, 1'b0);
      waitFor(1, 1'b1, dly(TR3, 1'b1), "fast rel");
    end
    delayShorten = 1'b0;
    for (int i = 0; i < 40; i++) begin
      r = ($random(seed) & 6) + 1;
      pack(3000 + ($random(seed) & 511), 3600, 300, 1'b0, 1'b0);
      idle(r - 1);
      pack(3600, 3600, 0, 1'b0, 1'b0);
    end
    `CHK("chopped oc", 1'b1, dischargeGate)
    pack(3600, 3600, 300, 1'b0, 1'b0);
    waitFor(1, 1'b0, TD3, "oc");
    pack(3600, 3600, 0, 1'b0, 1'b0);
    waitFor(1, 1'b1, TR3, "oc rel");
    $display("test current done");
    pack(3600, 3600, -600, 1'b0, 1'b1);
    waitFor(0, 1'b0, TD5, "xchg3");
    pack(0, 0, -600, 1'b0, 1'b1);
    waitFor(0, 1'b1, 0, "zero volt");
    pack(3600, 3600, 0, 1'b0, 1'b0);
    reset = 1'b1;
    idle(2);
    reset = 1'b0;
    idle(5);
    $display("test zero volt done");
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end
endmodule : bp_protect_fsm_tb
